// [verilog/audio_clk_ctrl.sv]
`timescale 1ns/100ps
// Overview of operation
// - polarity bit picks bit clock sampling edge
// - bit clock pin driven when direction set
// - master mode: device makes both clocks
// - master bit clock divides master clock
// - frame clock pin driven when direction set
// - master frame clock divides bit clock
// - host bit passed to dsp input port
// - dsp divider release gates dsp clock
// - dac divider release gates dac clocks
// - charge pump release gates oversample clock
// - either sync release clear stops dac at once
// - sync release restarts at frame start
// - master bit divider release, reset zero
// - master frame divider release, reset one
// - port starts slave, normal polarity
// - data out selects post or pre dsp
module audio_clk_ctrl
    import audio_clk_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // serial audio pins
    input wire logic BIT_CLOCK_IN,
    output logic BIT_CLOCK_OUT,
    output logic BIT_CLOCK_OE_N,
    input wire logic FRAME_CLOCK_IN,
    output logic FRAME_CLOCK_OUT,
    output logic FRAME_CLOCK_OE_N,
    input wire logic SERIAL_DATA_IN,
    // dsp side
    input wire logic DSP_OUT_DATA,
    output logic SERIAL_DATA_OUT,
    output logic DSP_HOST_INPUT_BIT,
    output logic DSP_CLOCK_EN,
    output logic DAC_CLOCK_EN,
    output logic OVERSAMPLE_CLOCK_EN,
    output logic SAMPLED_DATA,
    output logic FRAME_START
);

    reg_req_s req;
    logic [7:0] dir_q;
    logic [7:0] dsp_in_q;
    logic [7:0] rel_q;
    logic [7:0] sel_q;
    logic [7:0] bit_ratio_q;
    logic [7:0] frame_ratio_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    wire wr_dir = req.wr && (req.addr == ADDR_CLOCK_DIRECTION);
    wire wr_dsp = req.wr && (req.addr == ADDR_DSP_HOST_INPUT);
    wire wr_rel = req.wr && (req.addr == ADDR_DIVIDER_RELEASE);
    wire wr_sel = req.wr && (req.addr == ADDR_DATA_OUT_SELECT);
    wire wr_bratio = req.wr && (req.addr == ADDR_DIVIDER_RATIO);
    wire wr_fratio = req.wr && (req.addr == ADDR_FRAME_RATIO);

    // control registers; reset leaves slave mode, normal polarity
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            dir_q <= RESET_CLOCK_DIRECTION;
            dsp_in_q <= RESET_DSP_HOST_INPUT;
            rel_q <= RESET_DIVIDER_RELEASE;
            sel_q <= RESET_DATA_OUT_SELECT;
            bit_ratio_q <= RESET_DIVIDER_RATIO;
            frame_ratio_q <= RESET_FRAME_RATIO;
        end
        else
        begin
            if (wr_dir)
                dir_q <= merge(dir_q, req.wdata, MASK_CLOCK_DIRECTION);
            if (wr_dsp)
                dsp_in_q <= merge(dsp_in_q, req.wdata, MASK_DSP_HOST_INPUT);
            if (wr_rel)
                rel_q <= merge(rel_q, req.wdata, MASK_DIVIDER_RELEASE);
            if (wr_sel)
                sel_q <= merge(sel_q, req.wdata, MASK_DATA_OUT_SELECT);
            if (wr_bratio)
                bit_ratio_q <= req.wdata;
            if (wr_fratio)
                frame_ratio_q <= req.wdata;
        end
    end

    // unmapped addresses read zero
    always_comb
    begin
        case (req.addr)
            ADDR_CLOCK_DIRECTION: rdata_d = dir_q;
            ADDR_DSP_HOST_INPUT: rdata_d = dsp_in_q;
            ADDR_DIVIDER_RELEASE: rdata_d = rel_q;
            ADDR_DATA_OUT_SELECT: rdata_d = sel_q;
            ADDR_DIVIDER_RATIO: rdata_d = bit_ratio_q;
            ADDR_FRAME_RATIO: rdata_d = frame_ratio_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            rdata_q <= 8'h00;
        else if (req.rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end

    // read data stand in the cycle after each cycle with RD high and read zero otherwise
    assign RDATA = rdata_q;

    wire polarity = dir_q[POS_BIT_CLOCK_POLARITY];
    wire bit_master = dir_q[POS_BIT_CLOCK_OUTPUT_ENABLE];
    wire frame_master = dir_q[POS_FRAME_CLOCK_OUTPUT_ENABLE];
    wire bit_div_run = rel_q[POS_MASTER_BIT_DIVIDER_RELEASE];
    wire frame_div_run = rel_q[POS_MASTER_FRAME_DIVIDER_RELEASE];
    wire sync_run = rel_q[POS_OVERSAMPLE_SYNC_RELEASE] && rel_q[POS_SYNCHRONIZER_RELEASE];

    // pin synchronisers; the first stage feeds only the second
    // data and clock pass the same number of stages, so their edges stay aligned
    logic [1:0] bclk_meta_q;
    logic [1:0] bclk_sync_q;
    logic [1:0] fclk_meta_q;
    logic [1:0] fclk_sync_q;
    logic [1:0] din_meta_q;
    logic din_sync_q;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            bclk_meta_q <= 2'b00;
            fclk_meta_q <= 2'b00;
            din_meta_q <= 2'b00;
            bclk_sync_q <= 2'b00;
            fclk_sync_q <= 2'b00;
            din_sync_q <= 1'b0;
        end
        else
        begin
            bclk_meta_q <= {bclk_meta_q[0], BIT_CLOCK_IN};
            fclk_meta_q <= {fclk_meta_q[0], FRAME_CLOCK_IN};
            din_meta_q <= {din_meta_q[0], SERIAL_DATA_IN};
            bclk_sync_q <= {bclk_sync_q[0], bclk_meta_q[1]};
            fclk_sync_q <= {fclk_sync_q[0], fclk_meta_q[1]};
            din_sync_q <= din_meta_q[1];
        end
    end

    // master bit clock: master clock divided by 2*(ratio+1)
    logic [7:0] bit_cnt_q;
    logic bclk_gen_q;
    logic bclk_rise;
    logic bclk_fall;
    logic [7:0] frame_cnt_q;
    logic fclk_gen_q;

    // a ratio lowered below the running count wraps at once rather than after overflow
    wire bit_wrap = (bit_cnt_q >= bit_ratio_q);

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            bit_cnt_q <= 8'h00;
            bclk_gen_q <= 1'b0;
        end
        else if (!bit_div_run)
        begin
            bit_cnt_q <= 8'h00;
            bclk_gen_q <= 1'b0;
        end
        else if (bit_wrap)
        begin
            bit_cnt_q <= 8'h00;
            bclk_gen_q <= ~bclk_gen_q;
        end
        else
            bit_cnt_q <= bit_cnt_q + 8'h01;
    end

    // edges come from the pin in master mode too: our clock returns through the pad,
    // so the sampling edge sees the same delay as the data the source launches on it
    function automatic logic pin_edge(input logic [1:0] hist, input logic rising);
        pin_edge = rising ? (hist == 2'b01) : (hist == 2'b10);
    endfunction

    assign bclk_rise = pin_edge(bclk_sync_q, 1'b1);
    assign bclk_fall = pin_edge(bclk_sync_q, 1'b0);

    // master frame clock: bit clock divided by 2*(ratio+1), 128 fs default
    wire frame_wrap = (frame_cnt_q >= frame_ratio_q);
    wire launch_edge = polarity ? bclk_rise : bclk_fall;
    wire sample_edge = polarity ? bclk_fall : bclk_rise;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            frame_cnt_q <= 8'h00;
            fclk_gen_q <= 1'b0;
        end
        else if (!frame_div_run)
        begin
            frame_cnt_q <= 8'h00;
            fclk_gen_q <= 1'b0;
        end
        else if (launch_edge)
        begin
            if (frame_wrap)
            begin
                frame_cnt_q <= 8'h00;
                fclk_gen_q <= ~fclk_gen_q;
            end
            else
                frame_cnt_q <= frame_cnt_q + 8'h01;
        end
    end

    // frame start: falling frame clock, from pin or own generator
    logic fclk_prev_q;
    wire fclk_now = frame_master ? fclk_gen_q : fclk_sync_q[1];
    wire frame_start = fclk_prev_q && !fclk_now;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            fclk_prev_q <= 1'b0;
        else
            fclk_prev_q <= fclk_now;
    end

    // dac clock gate; stop is immediate, restart waits for a frame
    gate_state_e gate_q;
    gate_state_e gate_d;

    always_comb
    begin
        case (gate_q)
            GATE_STOPPED: gate_d = sync_run ? GATE_WAIT_FRAME : GATE_STOPPED;
            GATE_WAIT_FRAME:
            begin
                if (!sync_run)
                    gate_d = GATE_STOPPED;
                else if (frame_start)
                    gate_d = GATE_RUNNING;
                else
                    gate_d = GATE_WAIT_FRAME;
            end
            GATE_RUNNING: gate_d = sync_run ? GATE_RUNNING : GATE_STOPPED;
            default: gate_d = GATE_STOPPED;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            gate_q <= GATE_RUNNING;
        else
            gate_q <= gate_d;
    end

    // registered outputs
    logic bclk_out_q;
    logic bclk_oe_n_q;
    logic fclk_out_q;
    logic fclk_oe_n_q;
    logic sdo_q;
    logic dsp_bit_q;
    logic dsp_en_q;
    logic dac_en_q;
    logic osr_en_q;
    logic sample_q;
    logic fstart_q;

    // the next gate state lets the enable rise together with the frame start pulse
    wire dac_run = rel_q[POS_DAC_DIVIDER_RELEASE] && (gate_d == GATE_RUNNING);

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            bclk_out_q <= 1'b0;
            bclk_oe_n_q <= 1'b1;
            fclk_out_q <= 1'b0;
            fclk_oe_n_q <= 1'b1;
            sdo_q <= 1'b0;
            dsp_bit_q <= 1'b0;
            dsp_en_q <= 1'b0;
            dac_en_q <= 1'b0;
            osr_en_q <= 1'b0;
            sample_q <= 1'b0;
            fstart_q <= 1'b0;
        end
        else
        begin
            bclk_out_q <= bclk_gen_q;
            bclk_oe_n_q <= ~bit_master;
            fclk_out_q <= fclk_gen_q;
            fclk_oe_n_q <= ~frame_master;
            sdo_q <= sel_q[POS_DATA_OUT_SOURCE_SELECT] ? din_sync_q : DSP_OUT_DATA;
            dsp_bit_q <= dsp_in_q[POS_DSP_HOST_INPUT_BIT];
            dsp_en_q <= rel_q[POS_DSP_DIVIDER_RELEASE];
            dac_en_q <= dac_run;
            osr_en_q <= dac_run && rel_q[POS_CHARGE_PUMP_DIVIDER_RELEASE];
            if (sample_edge)
                sample_q <= din_sync_q;
            fstart_q <= frame_start;
        end
    end

    assign BIT_CLOCK_OUT = bclk_out_q;
    assign BIT_CLOCK_OE_N = bclk_oe_n_q;
    assign FRAME_CLOCK_OUT = fclk_out_q;
    assign FRAME_CLOCK_OE_N = fclk_oe_n_q;
    assign SERIAL_DATA_OUT = sdo_q;
    assign DSP_HOST_INPUT_BIT = dsp_bit_q;
    assign DSP_CLOCK_EN = dsp_en_q;
    assign DAC_CLOCK_EN = dac_en_q;
    assign OVERSAMPLE_CLOCK_EN = osr_en_q;
    assign SAMPLED_DATA = sample_q;
    assign FRAME_START = fstart_q;

endmodule

// [verilog/audio_clk_pkg.sv]
package audio_clk_pkg;

    // register offsets (byte addresses on the 8-bit register port)
    localparam logic [7:0] ADDR_CLOCK_DIRECTION = 8'h09;
    localparam logic [7:0] ADDR_DSP_HOST_INPUT = 8'h0a;
    localparam logic [7:0] ADDR_DIVIDER_RELEASE = 8'h0c;
    localparam logic [7:0] ADDR_DIVIDER_RATIO = 8'h20;
    localparam logic [7:0] ADDR_FRAME_RATIO = 8'h21;
    localparam logic [7:0] ADDR_DATA_OUT_SELECT = 8'h07;

    // field positions
    localparam int POS_BIT_CLOCK_POLARITY = 5;
    localparam int POS_BIT_CLOCK_OUTPUT_ENABLE = 4;
    localparam int POS_FRAME_CLOCK_OUTPUT_ENABLE = 0;
    localparam int POS_DSP_HOST_INPUT_BIT = 7;
    localparam int POS_DSP_DIVIDER_RELEASE = 6;
    localparam int POS_DAC_DIVIDER_RELEASE = 5;
    localparam int POS_CHARGE_PUMP_DIVIDER_RELEASE = 4;
    localparam int POS_OVERSAMPLE_SYNC_RELEASE = 3;
    localparam int POS_SYNCHRONIZER_RELEASE = 2;
    localparam int POS_MASTER_BIT_DIVIDER_RELEASE = 1;
    localparam int POS_MASTER_FRAME_DIVIDER_RELEASE = 0;
    localparam int POS_DATA_OUT_SOURCE_SELECT = 0;

    // writable masks and reset values
    localparam logic [7:0] MASK_CLOCK_DIRECTION = 8'h31;
    localparam logic [7:0] MASK_DSP_HOST_INPUT = 8'h80;
    localparam logic [7:0] MASK_DIVIDER_RELEASE = 8'h7f;
    localparam logic [7:0] MASK_DATA_OUT_SELECT = 8'h01;
    localparam logic [7:0] RESET_CLOCK_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_DSP_HOST_INPUT = 8'h00;
    localparam logic [7:0] RESET_DIVIDER_RELEASE = 8'h7d;
    localparam logic [7:0] RESET_DATA_OUT_SELECT = 8'h00;
    localparam logic [7:0] RESET_DIVIDER_RATIO = 8'h03;
    localparam logic [7:0] RESET_FRAME_RATIO = 8'h3f;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // dac clock gate states
    typedef enum logic [1:0] {
        GATE_STOPPED = 2'b00,
        GATE_WAIT_FRAME = 2'b01,
        GATE_RUNNING = 2'b11
    } gate_state_e;

endpackage

// [tb/audio_clk_ctrl_properties.sv]
`timescale 1ns/100ps
module audio_clk_ctrl_properties
    import audio_clk_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    // watched outputs
    input wire logic BIT_CLOCK_OE_N,
    input wire logic FRAME_CLOCK_OE_N,
    input wire logic DSP_HOST_INPUT_BIT,
    input wire logic DSP_CLOCK_EN,
    input wire logic DAC_CLOCK_EN,
    input wire logic OVERSAMPLE_CLOCK_EN,
    input wire logic FRAME_START
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire wr_dir = WR && ADDR == ADDR_CLOCK_DIRECTION;
    wire wr_rel = WR && ADDR == ADDR_DIVIDER_RELEASE;
    // two cycles allow for the output stage behind each register
    a_bit_dir_write: assert property (wr_dir |-> ##2 BIT_CLOCK_OE_N == !$past(WDATA[4], 2))
        else $error("bit clock direction wrong");
    a_frame_dir_write: assert property (wr_dir |-> ##2 FRAME_CLOCK_OE_N == !$past(WDATA[0], 2))
        else $error("frame clock direction wrong");
    a_host_bit_route: assert property (WR && ADDR == ADDR_DSP_HOST_INPUT |-> ##2 DSP_HOST_INPUT_BIT == $past(WDATA[7], 2))
        else $error("host bit not routed");
    a_dsp_clock_gate: assert property (wr_rel |-> ##2 DSP_CLOCK_EN == $past(WDATA[6], 2))
        else $error("dsp clock gate wrong");
    a_dac_halt: assert property (wr_rel && !WDATA[5] |-> ##2 !DAC_CLOCK_EN)
        else $error("dac clock not halted");
    a_osr_halt: assert property (wr_rel && !WDATA[4] |-> ##2 !OVERSAMPLE_CLOCK_EN)
        else $error("oversample clock not halted");
    a_sync_halt: assert property (wr_rel && !(WDATA[3] && WDATA[2]) |=> ##[0:1] !DAC_CLOCK_EN)
        else $error("sync clear did not stop dac");
    a_frame_restart: assert property ($rose(DAC_CLOCK_EN) && !$past(RST) && !$past(RST, 2) && !$past(wr_rel)
        && !$past(wr_rel, 2)
        |-> FRAME_START)
        else $error("dac restarted off frame start");
    a_start_pulse: assert property (FRAME_START |=> !FRAME_START)
        else $error("frame start longer than one cycle");
    c_restart: cover property ($rose(DAC_CLOCK_EN) && FRAME_START);
    c_master: cover property (!BIT_CLOCK_OE_N && !FRAME_CLOCK_OE_N);
    c_dsp_off: cover property ($fell(DSP_CLOCK_EN));
endmodule
bind audio_clk_ctrl audio_clk_ctrl_properties chk_u (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .BIT_CLOCK_OE_N,
    .FRAME_CLOCK_OE_N, .DSP_HOST_INPUT_BIT, .DSP_CLOCK_EN, .DAC_CLOCK_EN, .OVERSAMPLE_CLOCK_EN, .FRAME_START);

// [tb/audio_src_model.sv]
`timescale 1ns/100ps
module audio_src_model (
    // link state seen from the device
    input wire logic master,
    input wire logic pol,
    input wire logic dev_bclk,
    input wire logic dev_fclk,
    // pins driven by the source
    output logic bclk,
    output logic fclk,
    output logic sdata
);
    logic [7:0] word = 8'ha5;
    logic [5:0] cnt = 6'h00;
    logic own = 1'b0;
    always #160 own = !own;
    // in master mode data follows the device clocks, own clock is unused
    wire lc = master ? dev_bclk : own;
    // released pins show the inverse so a stale level is never mistaken for drive
    assign bclk = master ? !dev_bclk : own;
    assign fclk = master ? !dev_fclk : cnt[5];
    initial sdata = 1'b0;
    // launch on falling edge, or rising when inverted
    always @(negedge (lc ^ pol))
    begin
        cnt <= cnt + 6'h01;
        sdata <= word[cnt[2:0]];
    end
endmodule

// [tb/audio_clk_ctrl_tb_top.sv]
`timescale 1ns/100ps
module audio_clk_ctrl_tb_top;
    import audio_clk_pkg::*;
    logic CLK_SYS, RST, WR, RD, DSP_OUT_DATA, pol;
    logic [7:0] ADDR, WDATA;
    wire [7:0] RDATA;
    wire BIT_CLOCK_OUT, BIT_CLOCK_OE_N, FRAME_CLOCK_OUT, FRAME_CLOCK_OE_N, SERIAL_DATA_OUT, DSP_HOST_INPUT_BIT;
    wire DSP_CLOCK_EN, DAC_CLOCK_EN, OVERSAMPLE_CLOCK_EN, SAMPLED_DATA, FRAME_START, m_bclk, m_fclk, SERIAL_DATA_IN;
    wire BIT_CLOCK_IN = BIT_CLOCK_OE_N ? m_bclk : BIT_CLOCK_OUT;
    wire FRAME_CLOCK_IN = FRAME_CLOCK_OE_N ? m_fclk : FRAME_CLOCK_OUT;
    int errors = 0;
    int n_checks = 0;
    int bn = 0;
    int fn = 0;
    time bl = 0, bp = 0, fl = 0, fp = 0;
    audio_clk_ctrl dut_u (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .BIT_CLOCK_IN, .BIT_CLOCK_OUT,
        .BIT_CLOCK_OE_N, .FRAME_CLOCK_IN, .FRAME_CLOCK_OUT, .FRAME_CLOCK_OE_N, .SERIAL_DATA_IN, .DSP_OUT_DATA,
        .SERIAL_DATA_OUT, .DSP_HOST_INPUT_BIT, .DSP_CLOCK_EN, .DAC_CLOCK_EN, .OVERSAMPLE_CLOCK_EN, .SAMPLED_DATA,
        .FRAME_START);
    audio_src_model src_u (.master(!BIT_CLOCK_OE_N), .pol, .dev_bclk(BIT_CLOCK_IN), .dev_fclk(FRAME_CLOCK_IN),
        .bclk(m_bclk), .fclk(m_fclk), .sdata(SERIAL_DATA_IN));
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = !CLK_SYS;
    end
    always @(posedge BIT_CLOCK_OUT)
    begin
        bp = $time - bl;
        bl = $time;
        bn++;
    end
    always @(posedge FRAME_CLOCK_OUT)
    begin
        fp = $time - fl;
        fl = $time;
        fn++;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(negedge CLK_SYS);
        n_checks++;
        if (RDATA !== e)
        begin
            errors++;
            $display("BAD %0t read %h got %h expected %h", $time, a, RDATA, e);
        end
    endtask
    task automatic t_reset;
        rd(ADDR_CLOCK_DIRECTION, 8'h00);
        rd(ADDR_DIVIDER_RELEASE, 8'h7d);
        rd(8'h3f, 8'h00);
        chk(BIT_CLOCK_OE_N, 1'b1);
        chk(FRAME_CLOCK_OE_N, 1'b1);
        $display("reset test done");
    endtask
    task automatic t_route;
        wr(ADDR_DSP_HOST_INPUT, 8'hff);
        chk(DSP_HOST_INPUT_BIT, 1'b1);
        rd(ADDR_DSP_HOST_INPUT, 8'h80);
        wr(ADDR_DSP_HOST_INPUT, 8'h00);
        chk(DSP_HOST_INPUT_BIT, 1'b0);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge CLK_SYS);
            DSP_OUT_DATA <= v[0];
            repeat (3) @(posedge CLK_SYS);
            #1;
            chk(SERIAL_DATA_OUT, v[0]);
        end
        $display("route test done");
    endtask
    task automatic t_gates;
        wr(ADDR_DIVIDER_RELEASE, 8'h3d);
        chk(DSP_CLOCK_EN, 1'b0);
        chk(DAC_CLOCK_EN, 1'b1);
        wr(ADDR_DIVIDER_RELEASE, 8'h5d);
        chk(DSP_CLOCK_EN, 1'b1);
        chk(DAC_CLOCK_EN, 1'b0);
        chk(OVERSAMPLE_CLOCK_EN, 1'b0);
        wr(ADDR_DIVIDER_RELEASE, 8'h6d);
        chk(DAC_CLOCK_EN, 1'b1);
        chk(OVERSAMPLE_CLOCK_EN, 1'b0);
        wr(ADDR_DIVIDER_RELEASE, 8'h7d);
        chk(OVERSAMPLE_CLOCK_EN, 1'b1);
        $display("gate test done");
    endtask
    task automatic t_sync;
        int n;
        for (int b = 2; b < 4; b++)
        begin
            wr(ADDR_DIVIDER_RELEASE, 8'h7d & ~(8'h01 << b));
            chk(DAC_CLOCK_EN, 1'b0);
            wr(ADDR_DIVIDER_RELEASE, 8'h7d);
            chk(DAC_CLOCK_EN, 1'b0);
            n = 0;
            while (FRAME_START !== 1'b1 && n < 5000)
            begin
                @(posedge CLK_SYS);
                #1;
                n++;
            end
            chk(FRAME_START, 1'b1);
            chk(DAC_CLOCK_EN, 1'b1);
        end
        $display("sync test done");
    endtask
    task automatic t_sample(input logic p, input logic m);
        logic d;
        wr(ADDR_CLOCK_DIRECTION, {2'b00, p, m, 3'b000, m});
        wr(ADDR_DATA_OUT_SELECT, 8'h01);
        pol = p;
        repeat (2) @(posedge (BIT_CLOCK_IN ^ p));
        repeat (3)
        begin
            @(posedge (BIT_CLOCK_IN ^ p));
            d = SERIAL_DATA_IN;
            repeat (5) @(posedge CLK_SYS);
            #1;
            chk(SAMPLED_DATA, d);
            chk(SERIAL_DATA_OUT, d);
        end
        $display("sample test done");
    endtask
    task automatic t_master;
        int n0;
        wr(ADDR_FRAME_RATIO, 8'h1f);
        wr(ADDR_DIVIDER_RELEASE, 8'h7f);
        wr(ADDR_CLOCK_DIRECTION, 8'hff);
        rd(ADDR_CLOCK_DIRECTION, 8'h31);
        chk(BIT_CLOCK_OE_N, 1'b0);
        chk(FRAME_CLOCK_OE_N, 1'b0);
        repeat (2200) @(posedge CLK_SYS);
        chk(bp == 80, 1'b1);
        chk(fp == 5120, 1'b1);
        wr(ADDR_DIVIDER_RELEASE, 8'h7e);
        n0 = fn;
        repeat (1200) @(posedge CLK_SYS);
        chk(fn == n0, 1'b1);
        wr(ADDR_DIVIDER_RELEASE, 8'h7d);
        n0 = bn;
        repeat (64) @(posedge CLK_SYS);
        chk(bn == n0, 1'b1);
        wr(ADDR_DIVIDER_RELEASE, 8'h7f);
        $display("master test done");
    endtask
    initial
    begin
        #300000;
        errors++;
        test_done;
    end
    initial
    begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 8'h00;
        DSP_OUT_DATA = 1'b0;
        pol = 1'b0;
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset;
        t_route;
        t_gates;
        t_sync;
        t_sample(1'b0, 1'b0);
        t_sample(1'b1, 1'b0);
        t_master;
        t_sample(1'b0, 1'b1);
        test_done;
    end
endmodule
